// ==== hw/usb_host_schedule_pointer_regs.sv ====
// Schedule pointer and configure flag register group
`timescale 1ns/10ps
module usb_host_schedule_pointer_regs (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic [13:0] frame_index_counter,
    input wire logic [1:0] frame_list_size_code,
    input wire logic [31:0] capability_parameters_register,
    input wire logic [31:0] upper_address_segment_register,
    output logic [31:0] periodic_entry_addr,
    output logic [31:0] periodic_entry_addr_hi,
    output logic [31:0] async_head_addr,
    output logic [31:0] async_head_addr_hi,
    output logic [1:0] port_to_companion,
    output logic [1:0] port_to_this_hc
);
    // ****************************************
    // Types
    // ****************************************
    // Register selected by an offset; one decode serves writes and reads
    typedef enum logic [1:0] {
        sel_none = 2'h0,
        sel_base = 2'h1,
        sel_async = 2'h3,
        sel_flag = 2'h2
    } reg_sel_t;

    typedef struct packed {
        logic [31:0] base;
        logic [31:0] async_ptr;
        logic [31:0] flag;
        logic [31:0] rdata;
        logic [31:0] entry;
        logic [31:0] entry_hi;
        logic [31:0] head;
        logic [31:0] head_hi;
        logic [1:0] companion;
        logic [1:0] this_hc;
    } state_t;

    // ****************************************
    // State
    // ****************************************
    state_t cur;
    state_t next_cur;

    // ****************************************
    // Combinational helpers
    // ****************************************
    reg_sel_t addr_sel;
    logic [9:0] list_index;
    logic [31:0] upper_half;

    // ****************************************
    // Functions
    // ****************************************
    function automatic reg_sel_t decode_sel(input logic [7:0] addr);
        case (addr)
            sched_ptr_pkg::periodic_frame_list_base_off: begin
                decode_sel = sel_base;
            end
            sched_ptr_pkg::async_queue_head_pointer_off: begin
                decode_sel = sel_async;
            end
            sched_ptr_pkg::port_routing_config_flag_off: begin
                decode_sel = sel_flag;
            end
            default: begin
                decode_sel = sel_none;
            end
        endcase
    endfunction

    function automatic logic [31:0] upper_of(input logic [31:0] caps, input logic [31:0] seg);
        // Upper half stays zero on a 32-bit controller
        if (caps[sched_ptr_pkg::wide_addressing_capable_bit]) begin
            upper_of = seg;
        end
        else begin
            upper_of = sched_ptr_pkg::reg_reset;
        end
    endfunction

    function automatic logic [9:0] index_of(input logic [13:0] fic, input logic [1:0] code);
        // Index bits above N are forced to zero so smaller lists wrap
        unique case (code)
            sched_ptr_pkg::size_1024: begin
                index_of = fic[sched_ptr_pkg::index_msb_1024:sched_ptr_pkg::index_lsb];
            end
            sched_ptr_pkg::size_512: begin
                index_of = {1'h0, fic[sched_ptr_pkg::index_msb_512:sched_ptr_pkg::index_lsb]};
            end
            sched_ptr_pkg::size_256: begin
                index_of = {2'h0, fic[sched_ptr_pkg::index_msb_256:sched_ptr_pkg::index_lsb]};
            end
            // Reserved code takes the smallest list, so fetches never leave the aligned page
            default: begin
                index_of = {2'h0, fic[sched_ptr_pkg::index_msb_256:sched_ptr_pkg::index_lsb]};
            end
        endcase
    endfunction

    function automatic logic [31:0] write_value(input logic [31:0] data, input logic [31:0] keep);
        // Reserved positions are stored as zero whatever software sends
        write_value = data & keep;
    endfunction

    function automatic logic [31:0] read_value(input reg_sel_t sel, input state_t st);
        unique case (sel)
            sel_base: begin
                read_value = st.base;
            end
            sel_async: begin
                read_value = st.async_ptr;
            end
            sel_flag: begin
                read_value = st.flag;
            end
            sel_none: begin
                read_value = sched_ptr_pkg::reg_reset;
            end
        endcase
    endfunction

    function automatic logic [1:0] route_of(input logic [31:0] flag);
        route_of = {sched_ptr_pkg::num_ports{flag[sched_ptr_pkg::routing_configured_bit]}};
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_cur = cur;
        addr_sel = decode_sel(reg_addr);
        list_index = index_of(frame_index_counter, frame_list_size_code);
        upper_half = upper_of(capability_parameters_register, upper_address_segment_register);

        // Register writes
        if (reg_wr) begin
            unique case (addr_sel)
                sel_base: begin
                    next_cur.base = write_value(reg_wdata, sched_ptr_pkg::base_mask);
                end
                sel_async: begin
                    next_cur.async_ptr = write_value(reg_wdata, sched_ptr_pkg::async_mask);
                end
                sel_flag: begin
                    next_cur.flag = write_value(reg_wdata, sched_ptr_pkg::flag_mask);
                end
                sel_none: begin
                end
            endcase
        end

        // Read data lasts one cycle and is zero otherwise, so a stale word never looks fresh
        next_cur.rdata = sched_ptr_pkg::reg_reset;
        if (reg_rd) begin
            // A read in the same cycle as a write returns the old value
            next_cur.rdata = read_value(addr_sel, cur);
        end

        // Schedule addresses
        next_cur.entry = {
            cur.base[sched_ptr_pkg::addr_msb:sched_ptr_pkg::base_lsb],
            list_index,
            sched_ptr_pkg::entry_pad
        };
        next_cur.entry_hi = upper_half;
        next_cur.head = cur.async_ptr;
        next_cur.head_hi = upper_half;

        // Default routing only; per-port ownership overrides live elsewhere
        next_cur.this_hc = route_of(cur.flag);
        next_cur.companion = ~route_of(cur.flag);

        // Reset
        if (!resetn) begin
            next_cur = '0;
            next_cur.companion = '1;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk) begin
        cur <= next_cur;
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Every output is a flop of the state word
    assign reg_rdata = cur.rdata;
    assign periodic_entry_addr = cur.entry;
    assign periodic_entry_addr_hi = cur.entry_hi;
    assign async_head_addr = cur.head;
    assign async_head_addr_hi = cur.head_hi;
    assign port_to_companion = cur.companion;
    assign port_to_this_hc = cur.this_hc;
endmodule

// ==== hw/sched_ptr_pkg.sv ====
// Constants for the schedule pointer register group
package sched_ptr_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] periodic_frame_list_base_off = 8'h34;
    localparam logic [7:0] async_queue_head_pointer_off = 8'h38;
    localparam logic [7:0] port_routing_config_flag_off = 8'h60;
    localparam logic [31:0] reg_reset = 32'h00000000;
    localparam logic [31:0] base_mask = 32'hfffff000;
    localparam logic [31:0] async_mask = 32'hffffffe0;
    localparam logic [31:0] flag_mask = 32'h00000001;
    localparam int routing_configured_bit = 0;
    localparam int wide_addressing_capable_bit = 0;
    // ****************************************
    // Address composition
    // ****************************************
    localparam int addr_msb = 31;
    localparam int base_lsb = 12;
    localparam int index_lsb = 3;
    localparam int index_msb_1024 = 12;
    localparam int index_msb_512 = 11;
    localparam int index_msb_256 = 10;
    localparam logic [1:0] entry_pad = 2'h0;
    // ****************************************
    // Frame list sizes
    // ****************************************
    localparam logic [1:0] size_1024 = 2'h0;
    localparam logic [1:0] size_512 = 2'h1;
    localparam logic [1:0] size_256 = 2'h2;
    localparam int num_ports = 2;
endpackage

// ==== sim/sched_ptr_asserts.sv ====
// Concurrent checks for the schedule pointer register group
`timescale 1ns/10ps
module sched_ptr_chk (input core_clk, resetn, reg_wr, reg_rd, input [7:0] reg_addr,
    input [13:0] frame_index_counter, input [1:0] frame_list_size_code, port_to_this_hc, port_to_companion,
    input [31:0] reg_wdata, reg_rdata, capability_parameters_register, upper_address_segment_register,
    input [31:0] periodic_entry_addr, periodic_entry_addr_hi, async_head_addr);
    logic [1:0] up;
    always_ff @(posedge core_clk) up <= {up[0], resetn};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Reset on either edge of the window would clear the derived outputs
    sequence s_w(a); up == 2'h3 && $past(reg_wr, 2) && $past(reg_addr, 2) == a; endsequence
    property p_brd; $past(reg_rd) && $past(reg_addr) == 8'h34 |-> reg_rdata[11:0] == 12'h0; endproperty
    a_brd: assert property (p_brd) else $error("base low bits");
    property p_ard; $past(reg_rd) && $past(reg_addr) == 8'h38 |-> reg_rdata[4:0] == 5'h0; endproperty
    a_ard: assert property (p_ard) else $error("async low bits");
    property p_hi; up[0] |-> periodic_entry_addr_hi == ($past(capability_parameters_register[0]) ?
        $past(upper_address_segment_register) : 32'h0); endproperty
    a_hi: assert property (p_hi) else $error("upper address");
    property p_ix; up[0] && $past(frame_list_size_code) != 2'h3 |-> periodic_entry_addr[11:0] ==
        {$past(frame_index_counter[12:3]) & (10'h3ff >> $past(frame_list_size_code)), 2'h0}; endproperty
    a_ix: assert property (p_ix) else $error("list index");
    property p_ba; s_w(8'h34) |-> periodic_entry_addr[31:12] == $past(reg_wdata[31:12], 2); endproperty
    a_ba: assert property (p_ba) else $error("list base");
    property p_qh; s_w(8'h38) |-> async_head_addr == ($past(reg_wdata, 2) & 32'hffffffe0); endproperty
    a_qh: assert property (p_qh) else $error("queue head");
    property p_rt; port_to_this_hc == ~port_to_companion && ^port_to_this_hc == 1'h0; endproperty
    a_rt: assert property (p_rt) else $error("mixed routing");
    property p_rw; s_w(8'h60) |-> port_to_this_hc == {2{$past(reg_wdata[0], 2)}}; endproperty
    a_rw: assert property (p_rw) else $error("routing flag");
endmodule
bind usb_host_schedule_pointer_regs sched_ptr_chk u_chk (.*);

// ==== sim/sched_host.sv ====
// Host software model issuing register reads and writes
`timescale 1ns/10ps
module sched_host (input core_clk, input [31:0] reg_rdata, output logic [7:0] reg_addr = '0,
    output logic reg_wr = '0, reg_rd = '0, output logic [31:0] reg_wdata = '0);
    // Called on a rising edge; released data shows its inverse so stale values cannot pass
    task automatic wr(input [7:0] a, input [31:0] d);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'h1};
        @(posedge core_clk) {reg_wdata, reg_wr} <= {~d, 1'h0};
        @(posedge core_clk);
    endtask
    task automatic rd(input [7:0] a, output [31:0] d);
        {reg_addr, reg_rd} <= {a, 1'h1};
        @(posedge core_clk) reg_rd <= 1'h0;
        @(posedge core_clk) d = reg_rdata;
    endtask
endmodule

// ==== sim/usb_host_schedule_pointer_regs_bench.sv ====
// Bench for the schedule pointer register group
`timescale 1ns/10ps
module usb_host_schedule_pointer_regs_bench;
    logic core_clk = '0, resetn = '0, reg_wr, reg_rd;
    logic [1:0] frame_list_size_code = '0, port_to_companion, port_to_this_hc;
    logic [13:0] frame_index_counter = 14'h2abc;
    logic [31:0] capability_parameters_register = '0, upper_address_segment_register = 32'h5, reg_wdata, reg_rdata, d;
    logic [31:0] periodic_entry_addr, periodic_entry_addr_hi, async_head_addr, async_head_addr_hi;
    logic [7:0] reg_addr, offs [4] = '{8'h34, 8'h38, 8'h60, 8'h3c};
    logic [31:0] msk [4] = '{32'hfffff000, 32'hffffffe0, 32'h1, 32'h0};
    int miscompares = 0, samples_checked = 0;
    usb_host_schedule_pointer_regs DUT (.*);
    sched_host host (.*);
    initial forever #25 core_clk = ~core_clk;
    initial #20000 begin
        miscompares++;
        finish_test;
    end
    task automatic chk(input string n, input [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic finish_test;
        $display("%0d checks, %0d mismatches", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'h1;
        @(posedge core_clk) chk("route", {port_to_companion, port_to_this_hc}, 32'hc);
        for (int i = 0; i < 4; i++) begin
            host.rd(offs[i], d);
            chk("reset", d, 32'h0);
            host.wr(offs[i], '1);
            host.rd(offs[i], d);
            chk("mask", d, msk[i]);
        end
        chk("route", {port_to_companion, port_to_this_hc}, 32'h3);
        $display("register test done");
        host.wr(8'h34, 32'h12345000);
        host.wr(8'h38, 32'habcdef40);
        for (int c = 0; c < 4; c++) begin
            frame_list_size_code <= c[1:0];
            capability_parameters_register <= c[0];
            d = {20'h12345, 10'(frame_index_counter >> 3) & (10'h3ff >> (c == 3 ? 2 : c)), 2'h0};
            repeat (2) @(posedge core_clk);
            chk("entry", periodic_entry_addr, d);
            chk("upper", periodic_entry_addr_hi, c[0] ? 32'h5 : 32'h0);
            chk("head upper", async_head_addr_hi, c[0] ? 32'h5 : 32'h0);
        end
        chk("queue head", async_head_addr, 32'habcdef40);
        host.wr(8'h60, 32'h1);
        repeat (2) @(posedge core_clk);
        chk("route", {port_to_companion, port_to_this_hc}, 32'h3);
        $display("pointer test done");
        finish_test;
    end
endmodule
